// ---- hw/shift_pkg.sv ----
// Constants, register map and types shared by the shift register pair.
// Assumes an APB master with 32-bit data and byte addresses.
package shift_pkg;

  // Register byte addresses on the APB side.
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STEP_ADDR   = 12'h004;
  localparam logic [11:0] DATA_ADDR   = 12'h008;
  localparam logic [11:0] STATUS_ADDR = 12'h00C;

  // Control register field positions.
  localparam int unsigned CTRL_CLEAR_N_BIT = 0;
  localparam int unsigned CTRL_MODE_LO_BIT = 1;
  localparam int unsigned CTRL_MODE_HI_BIT = 2;
  localparam int unsigned CTRL_SHIFT_BIT   = 3;
  localparam int unsigned CTRL_J_BIT       = 4;
  localparam int unsigned CTRL_K_N_BIT     = 5;
  localparam int unsigned CTRL_RIGHT_BIT   = 6;
  localparam int unsigned CTRL_LEFT_BIT    = 7;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0009;

  // Step register field and status register field positions.
  localparam int unsigned STEP_GO_BIT     = 0;
  localparam int unsigned STAT_UNIV_LSB   = 0;
  localparam int unsigned STAT_PAR_LSB    = 4;
  localparam int unsigned STAT_INV_BIT    = 8;
  localparam int unsigned STAT_EMPTY_BIT  = 9;
  localparam int unsigned STAT_FULL_BIT   = 10;
  localparam int unsigned STAT_PEND_BIT   = 11;

  // Parallel data FIFO shape; low nibble feeds the universal register.
  localparam int unsigned FIFO_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned UNIV_LSB   = 0;
  localparam int unsigned PAR_LSB    = 4;

  // Universal register mode codes, high select bit first.
  localparam logic [1:0] MODE_HOLD  = 2'h0;
  localparam logic [1:0] MODE_RIGHT = 2'h1;
  localparam logic [1:0] MODE_LEFT  = 2'h2;
  localparam logic [1:0] MODE_LOAD  = 2'h3;

  // States of the step sequencer.
  typedef enum logic [0:0] {STEP_IDLE, STEP_WAIT} step_state_t;

endpackage

// ---- hw/sync_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sync_fifo
  import shift_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic        push;
  logic        pop;

  // Full and empty come straight from the count, so they never lie.
  assign in_ready_o  = (s.count != CW'(DEPTH));
  assign out_valid_o = (s.count != '0);
  assign out_data_o  = s.mem[s.rd_ptr];
  assign count_o     = s.count;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;

  // Pointers wrap explicitly so a depth that is not a power of two works.
  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr_ptr] = in_data_i;
      next_s.wr_ptr = (s.wr_ptr == PW'(DEPTH-1)) ? '0 : s.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_s.rd_ptr = (s.rd_ptr == PW'(DEPTH-1)) ? '0 : s.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_s.count = s.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_s.count = s.count - 1'b1;
    end
  end

  // The storage is cleared too, which keeps the read data defined.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule

// ---- hw/universal_shift4.sv ----
// Four-stage universal register: hold, shift right, shift left, load.
// Assumes a one-cycle step enable on the shared clock.
`timescale 1ns/1ps
module universal_shift4
  import shift_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       step_i,
  input  wire logic       clear_n_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       right_i,
  input  wire logic       left_i,
  input  wire logic [3:0] data_i,
  output logic [3:0]      stage_o
);

  typedef struct packed {
    logic [3:0] stage;
  } univ_state_t;

  univ_state_t s;
  univ_state_t next_s;

  assign stage_o = s.stage;

  // Bit 0 is the first stage, bit 3 the last.
  always_comb
  begin
    next_s = s;
    if (!clear_n_i)
    begin
      next_s.stage = 4'h0; // RULE1
    end
    else if (step_i) // RULE2
    begin
      case (mode_i) // RULE3
        MODE_LOAD:  next_s.stage = data_i; // RULE6
        MODE_RIGHT: next_s.stage = {s.stage[2:0], right_i}; // RULE4
        MODE_LEFT:  next_s.stage = {left_i, s.stage[3:1]}; // RULE5
        MODE_HOLD:  next_s.stage = s.stage;
        default:    next_s.stage = s.stage;
      endcase
    end
  end

  // State only moves on a step or under clear, so idle cycles leave it alone.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s; // RULE12
    end
  end

endmodule

// ---- hw/four_bit_shift_registers.sv ----
// Top of the shift register pair: APB slave, step sequencer, data FIFO,
// the parallel-access register and an instance of the universal one.
// Assumes a single 50 MHz clock and an APB master on the same clock.
// Software owns every input: modes, serial and first-stage controls
// are control register bits, and the register clock is a step request.
// Limitation: clear acts at a write edge, not between clock edges.
// A load step takes one FIFO word for both registers at once.
//
// Notes on behaviour
// RULE1: Clear low empties all stages at once; the inverted last output goes high.
// RULE2: With clear inactive, stages change only on a register clock step.
// RULE3: Universal mode: 11 loads, 01 shifts right, 10 shifts left, 00 holds.
// RULE4: Right shift takes the right serial input into stage 0, moves upward.
// RULE5: Left shift takes the left serial input into stage 3, moves downward.
// RULE6: Parallel load copies each data bit into its own stage.
// RULE7: Parallel-access register loads when shift/load is low, shifts when high.
// RULE8: Shift moves stages up; stage 0 follows J and inverted K.
// RULE9: J tied to inverted K makes stage 0 a plain D input.
// RULE10: An extra output always shows the complement of the last stage.
// RULE11: Outside logic may feed last outputs back to J and K for counting.
// RULE12: Without a clock step the contents never change; here a clear write also empties them without a step.
`timescale 1ns/1ps
module four_bit_shift_registers
  import shift_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic [3:0]       UNIV_STAGE_OUT_O,
  output logic [3:0]       PAR_STAGE_OUT_O,
  output logic             STAGE3_OUT_INVERTED_O
);

  // Everything this module remembers, registered as one word.
  typedef struct packed {
    logic        master_clear_n;
    logic [1:0]  mode_select;
    logic        shift_select;
    logic        j_in;
    logic        k_in_n;
    logic        right_serial;
    logic        left_serial;
    step_state_t step_state;
    logic [3:0]  par_stage;
    logic        stage3_out_inverted;
    logic [31:0] prdata;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  // Bus decode and handshake terms.
  logic        setup_phase;
  logic        access_phase;
  logic        hit_ctrl;
  logic        hit_step;
  logic        hit_data;
  logic        hit_status;
  logic        mapped;
  logic        ready;
  logic        done;
  logic        ctrl_wr;
  logic        step_wr;
  logic        data_wr;

  // Sequencer and datapath terms.
  logic        clear_eff_n;
  logic        need_load;
  logic        fire;
  logic        register_clock;
  logic        pop;
  logic        first_next;
  logic [3:0]  univ_stage;
  logic [3:0]  par_next;

  // FIFO connections.
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic [3:0]  fifo_count;

  // Address decode of the four word registers.
  assign setup_phase  = PSEL_I & ~PENABLE_I;
  assign access_phase = PSEL_I & PENABLE_I;
  assign hit_ctrl     = (PADDR_I == CTRL_ADDR);
  assign hit_step     = (PADDR_I == STEP_ADDR);
  assign hit_data     = (PADDR_I == DATA_ADDR);
  assign hit_status   = (PADDR_I == STATUS_ADDR);
  assign mapped       = hit_ctrl | hit_step | hit_data | hit_status;


  // Waiting on the bus, rather than dropping a write, keeps software
  // simple: a step or data write can never be lost, only delayed.
  // Back-pressure on the bus: a step waits for the previous one to finish,
  // and a data word waits for room in the FIFO. Reads never wait.
  always_comb
  begin
    ready = 1'b1;
    if (PWRITE_I && hit_step)
    begin
      ready = (s.step_state == STEP_IDLE);
    end
    else if (PWRITE_I && hit_data)
    begin
      ready = fifo_in_ready;
    end
  end


  // An unmapped address still completes at once, with an error, so a
  // stray access cannot stall the bus.
  // Handshake outputs are combinational; read data comes from a flop.
  assign PREADY_O  = access_phase & ready;
  assign done      = access_phase & ready;
  assign PSLVERR_O = done & ~mapped;
  assign PRDATA_O  = s.prdata;

  // Writes take effect only at the completing edge of the access phase.
  assign ctrl_wr = done & PWRITE_I & hit_ctrl;
  assign step_wr = done & PWRITE_I & hit_step & PWDATA_I[STEP_GO_BIT];
  assign data_wr = done & PWRITE_I & hit_data;

  // A clear written now acts on this very edge, not one cycle later, so
  // the stages empty as soon as the write lands.
  assign clear_eff_n = ctrl_wr ? PWDATA_I[CTRL_CLEAR_N_BIT]
                               : s.master_clear_n;

  // A step needs a FIFO word when either register is set to load.
  assign need_load = (s.mode_select == MODE_LOAD) | ~s.shift_select;


  // Firing waits in the sequencer, not on the bus, so software can post
  // a step first and the data word after it.
  // A pending step fires once its data is there; under clear it fires at
  // once and is thrown away, so an empty FIFO cannot wedge the sequencer.
  assign fire = (s.step_state == STEP_WAIT) &
                (~clear_eff_n | ~need_load | fifo_out_valid);

  // The register clock is a one-cycle enable, gated off by clear.
  assign register_clock = fire & clear_eff_n; // RULE2
  assign pop            = register_clock & need_load;


  // Tying J and inverted K together turns this into a plain data input.
  // Stage 0 of the parallel-access register is a JK stage with inverted K:
  // low-low clears, high-high sets, low-high holds, high-low toggles.
  assign first_next = (s.j_in & ~s.par_stage[0]) |
                      (s.k_in_n & s.par_stage[0]); // RULE8 RULE9

  // Shift moves each stage one place toward the last; load copies data.
  always_comb
  begin
    if (!s.shift_select)
    begin
      par_next = fifo_out_data[PAR_LSB +: 4]; // RULE7 RULE6
    end
    else
    begin
      par_next = {s.par_stage[2:0], first_next}; // RULE8
    end
  end


  // The FIFO decouples bus writes from steps; its head word is what the
  // parallel inputs see, and it is popped only by a load step.
  // Data FIFO between the bus and the parallel inputs of both registers.
  sync_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (data_wr),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (PWDATA_I[7:0]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data),
    .count_o     (fifo_count)
  );


  // Both registers share one enable so they always step together.
  // Universal register, stepped by the same enable.
  universal_shift4 u_univ (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .step_i    (register_clock),
    .clear_n_i (clear_eff_n),
    .mode_i    (s.mode_select),
    .right_i   (s.right_serial),
    .left_i    (s.left_serial),
    .data_i    (fifo_out_data[UNIV_LSB +: 4]),
    .stage_o   (univ_stage)
  );

  // Next state of control fields, sequencer, stages and read data.
  always_comb
  begin
    next_s = s;


    // Control register write; the new modes apply from the next step on.
    // Bits above the control field are ignored.
    if (ctrl_wr)
    begin
      next_s.master_clear_n = PWDATA_I[CTRL_CLEAR_N_BIT];
      next_s.mode_select    = {PWDATA_I[CTRL_MODE_HI_BIT],
                               PWDATA_I[CTRL_MODE_LO_BIT]};
      next_s.shift_select   = PWDATA_I[CTRL_SHIFT_BIT];
      next_s.j_in           = PWDATA_I[CTRL_J_BIT];
      next_s.k_in_n         = PWDATA_I[CTRL_K_N_BIT];
      next_s.right_serial   = PWDATA_I[CTRL_RIGHT_BIT];
      next_s.left_serial    = PWDATA_I[CTRL_LEFT_BIT];
    end


    // Step sequencer: one register clock per accepted step write, none under clear.
    // Only one step is ever outstanding; a second step write waits on
    // the bus until the first has fired.
    case (s.step_state)
      STEP_IDLE:
      begin
        if (step_wr)
        begin
          next_s.step_state = STEP_WAIT;
        end
      end
      STEP_WAIT:
      begin
        if (fire)
        begin
          next_s.step_state = STEP_IDLE;
        end
      end
      default:
      begin
        next_s.step_state = STEP_IDLE;
      end
    endcase


    // Parallel-access stages; the complement is kept beside the last one.
    // Keeping it in a flop of its own makes it a clean register output,
    // at the cost of one flop that must track the last stage exactly.
    if (!clear_eff_n)
    begin
      next_s.par_stage           = 4'h0; // RULE1
      next_s.stage3_out_inverted = 1'b1; // RULE1
    end
    else if (register_clock)
    begin
      next_s.par_stage           = par_next;
      next_s.stage3_out_inverted = ~par_next[3]; // RULE10
    end


    // Read data is captured in the setup cycle and held for the access.
    // Capturing early gives a flop output and needs no read wait state.
    // Unmapped reads return zero.
    if (setup_phase && !PWRITE_I)
    begin
      next_s.prdata = 32'h0000_0000;
      if (hit_ctrl)
      begin
        next_s.prdata[CTRL_CLEAR_N_BIT] = s.master_clear_n;
        next_s.prdata[CTRL_MODE_LO_BIT] = s.mode_select[0];
        next_s.prdata[CTRL_MODE_HI_BIT] = s.mode_select[1];
        next_s.prdata[CTRL_SHIFT_BIT]   = s.shift_select;
        next_s.prdata[CTRL_J_BIT]       = s.j_in;
        next_s.prdata[CTRL_K_N_BIT]     = s.k_in_n;
        next_s.prdata[CTRL_RIGHT_BIT]   = s.right_serial;
        next_s.prdata[CTRL_LEFT_BIT]    = s.left_serial;
      end
      else if (hit_step)
      begin
        next_s.prdata[STEP_GO_BIT] = (s.step_state == STEP_WAIT);
      end
      else if (hit_data)
      begin
        next_s.prdata[3:0] = fifo_count;
      end
      else if (hit_status)
      begin
        next_s.prdata[STAT_UNIV_LSB +: 4] = univ_stage;
        next_s.prdata[STAT_PAR_LSB +: 4]  = s.par_stage;
        next_s.prdata[STAT_INV_BIT]       = s.stage3_out_inverted;
        next_s.prdata[STAT_EMPTY_BIT]     = ~fifo_out_valid;
        next_s.prdata[STAT_FULL_BIT]      = ~fifo_in_ready;
        next_s.prdata[STAT_PEND_BIT]      = (s.step_state == STEP_WAIT);
      end
    end
  end


  // Reset is synchronous, so it needs at least one rising edge.
  // Reset leaves clear released, the universal register holding and the
  // parallel-access register in shift, with all stages empty.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      s                     <= '0;
      s.master_clear_n      <= CTRL_RESET[CTRL_CLEAR_N_BIT];
      s.mode_select         <= {CTRL_RESET[CTRL_MODE_HI_BIT],
                                CTRL_RESET[CTRL_MODE_LO_BIT]};
      s.shift_select        <= CTRL_RESET[CTRL_SHIFT_BIT];
      s.step_state          <= STEP_IDLE;
      s.stage3_out_inverted <= 1'b1;
    end
    else
    begin
      s <= next_s; // RULE12
    end
  end


  // Stage outputs come straight from flops.
  // They change only at the edge where a step fires or clear is written.
  assign UNIV_STAGE_OUT_O      = univ_stage;
  assign PAR_STAGE_OUT_O       = s.par_stage;
  assign STAGE3_OUT_INVERTED_O = s.stage3_out_inverted; // RULE10

endmodule

// ---- dv/four_bit_shift_registers_checker.sv ----
// Checker for the shift register pair, bound to its top module.
// Assumes every register access is seen at the APB ports of that top.
`timescale 1ns/1ps
module shift_checker
  import shift_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [3:0]  UNIV_STAGE_OUT_O,
  input wire logic [3:0]  PAR_STAGE_OUT_O,
  input wire logic        STAGE3_OUT_INVERTED_O
);
  logic [7:0] ctrl;
  logic       wr;
  logic       step_wr;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // A completed write, and a step request that needs no FIFO word.
  assign wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  assign step_wr = wr && PADDR_I == STEP_ADDR && PWDATA_I[0] && ctrl[0]
                   && ctrl[3] && ctrl[2:1] != MODE_LOAD;

  // Shadow of the control word; expected shifts are derived from it.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      ctrl <= CTRL_RESET[7:0];
    else if (wr && PADDR_I == CTRL_ADDR)
      ctrl <= PWDATA_I[7:0];
  end

  property p_inv;
    STAGE3_OUT_INVERTED_O == !PAR_STAGE_OUT_O[3];
  endproperty
  a_inv: assert property (p_inv)
    else $error("inverted output is not the complement");
  property p_clear;
    wr && PADDR_I == CTRL_ADDR && !PWDATA_I[0] |=> UNIV_STAGE_OUT_O == 4'h0
      && PAR_STAGE_OUT_O == 4'h0 && STAGE3_OUT_INVERTED_O;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not empty the stages");
  property p_quiet;
    $changed(UNIV_STAGE_OUT_O) || $changed(PAR_STAGE_OUT_O)
      |-> $past(wr) || $past(wr, 2);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("stages moved without a step");
  property p_right;
    step_wr && ctrl[2:1] == MODE_RIGHT
      |-> ##2 UNIV_STAGE_OUT_O == {$past(UNIV_STAGE_OUT_O[2:0]), ctrl[6]};
  endproperty
  a_right: assert property (p_right)
    else $error("right shift wrong");
  property p_left;
    step_wr && ctrl[2:1] == MODE_LEFT
      |-> ##2 UNIV_STAGE_OUT_O == {ctrl[7], $past(UNIV_STAGE_OUT_O[3:1])};
  endproperty
  a_left: assert property (p_left)
    else $error("left shift wrong");
  property p_hold;
    step_wr && ctrl[2:1] == MODE_HOLD |-> ##2 $stable(UNIV_STAGE_OUT_O);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold mode changed the universal stages");
  property p_par;
    step_wr |-> ##2 PAR_STAGE_OUT_O == {$past(PAR_STAGE_OUT_O[2:0]),
      (ctrl[4] & !$past(PAR_STAGE_OUT_O[0]))
      | (ctrl[5] & $past(PAR_STAGE_OUT_O[0]))};
  endproperty
  a_par: assert property (p_par)
    else $error("parallel-access shift wrong");
  property p_dtype;
    step_wr && ctrl[4] == ctrl[5] |-> ##2 PAR_STAGE_OUT_O[0] == ctrl[4];
  endproperty
  a_dtype: assert property (p_dtype)
    else $error("first stage does not follow the common input");

  c_step: cover property (step_wr);
  c_push: cover property (wr && PADDR_I == DATA_ADDR);
  c_err: cover property (PSLVERR_O);
endmodule

bind four_bit_shift_registers shift_checker i_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .UNIV_STAGE_OUT_O(UNIV_STAGE_OUT_O), .PAR_STAGE_OUT_O(PAR_STAGE_OUT_O),
  .STAGE3_OUT_INVERTED_O(STAGE3_OUT_INVERTED_O)
);

// ---- dv/apb_master_model.sv ----
// Behavioural APB master standing in for the surrounding logic.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ps
module apb_master_model
(
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:0]      paddr_o,
  output logic [31:0]      pwdata_o
);
  // The bus idles with every request line low from time zero.
  initial
  begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 12'h000;
    pwdata_o  = 32'h0000_0000;
  end

  // One transfer; the request is held until ready is high at an edge.
  // Ready, read data and error are taken at that rising edge itself.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    logic ok;
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      ok = pready_i;
      r  = prdata_i;
      e  = pslverr_i;
    end
    while (!ok);
  endtask

  // Releases the bus after the last transfer of a burst.
  task automatic idle;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// ---- dv/test_four_bit_shift_registers.sv ----
// Self-checking bench for the shift register pair.
// Assumes the master model and the bound checker are compiled with it.
`timescale 1ns/1ps
module test_four_bit_shift_registers
  import shift_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] data;
    logic [3:0] univ;
    logic [3:0] par;
  } row_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  univ;
  logic [3:0]  par;
  logic        inv;
  logic [31:0] r;
  logic [3:0]  p;
  logic        q;
  int          bad_count = 0;
  int          n_compared = 0;

  // Control word, FIFO word, expected universal and parallel stages.
  row_t rows [7] = '{
    '{8'h07, 8'hA5, 4'h5, 4'hA},
    '{8'h6B, 8'h00, 4'hB, 4'h4},
    '{8'h1D, 8'h00, 4'h5, 4'h9},
    '{8'h39, 8'h00, 4'h5, 4'h3},
    '{8'h09, 8'h00, 4'h5, 4'h6},
    '{8'hC9, 8'h00, 4'h5, 4'hC},
    '{8'h01, 8'h3C, 4'h5, 4'h3}
  };

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  apb_master_model i_bus (
    .clk_i(clk), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata)
  );

  four_bit_shift_registers i_dut (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .UNIV_STAGE_OUT_O(univ), .PAR_STAGE_OUT_O(par),
    .STAGE3_OUT_INVERTED_O(inv)
  );

  // Comparison and bus helpers shared by every scenario.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rr;
    logic        ee;
    i_bus.xfer(1'b1, a, d, rr, ee);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] rr);
    logic ee;
    i_bus.xfer(1'b0, a, 32'h0000_0000, rr, ee);
  endtask

  // Leaves room for a pending step to fire and settle.
  task automatic gap;
    i_bus.idle;
    repeat (2) @(posedge clk);
  endtask

  // Output pins are looked at mid-cycle, away from any edge.
  task automatic port(input logic [3:0] u, input logic [3:0] pa);
    @(negedge clk);
    chk({23'h0, inv, par, univ}, {23'h0, !pa[3], pa, u});
    @(posedge clk);
  endtask

  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The run takes a few hundred cycles; this bound catches a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("FAIL %0t watchdog expired", $time);
    close_out;
  end

  // Main sequence: reset, table rows, then the awkward cases.
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(CTRL_ADDR, r);
    chk(r, CTRL_RESET);
    rd(STATUS_ADDR, r);
    chk(r, 32'h0000_0300);
    i_bus.xfer(1'b1, 12'h010, 32'h0000_00FF, r, q);
    chk({31'h0, q}, 32'h0000_0001);
    i_bus.xfer(1'b0, 12'h010, 32'h0000_0000, r, q);
    chk({r[30:0], q}, 32'h0000_0001);
    foreach (rows[i])
    begin
      wr(CTRL_ADDR, {24'h0, rows[i].ctrl});
      if (rows[i].ctrl[2:1] == MODE_LOAD || !rows[i].ctrl[3])
        wr(DATA_ADDR, {24'h0, rows[i].data});
      wr(STEP_ADDR, 32'h0000_0001);
      gap;
      rd(STATUS_ADDR, r);
      chk({23'h0, r[8:0]}, {23'h0, !rows[i].par[3], rows[i].par,
          rows[i].univ});
    end
    // A load step with the FIFO empty waits for a word.
    wr(CTRL_ADDR, 32'h0000_0007);
    wr(STEP_ADDR, 32'h0000_0001);
    gap;
    rd(STATUS_ADDR, r);
    chk(r, 32'h0000_0B35);
    wr(DATA_ADDR, 32'h0000_0096);
    gap;
    port(4'h6, 4'h9);
    // Fill the FIFO to full, then drain it one load at a time.
    for (int k = 0; k < 8; k++)
      wr(DATA_ADDR, {24'h0, k[3:0], k[3:0]});
    rd(DATA_ADDR, r);
    chk(r, 32'h0000_0008);
    rd(STATUS_ADDR, r);
    chk({28'h0, r[11:8]}, 32'h0000_0004);
    for (int k = 0; k < 8; k++)
    begin
      wr(STEP_ADDR, 32'h0000_0001);
      gap;
      port(k[3:0], k[3:0]);
    end
    rd(STATUS_ADDR, r);
    chk({28'h0, r[11:8]}, 32'h0000_0003);
    // Clear empties at once and swallows steps without a pop.
    wr(DATA_ADDR, 32'h0000_005A);
    wr(CTRL_ADDR, 32'h0000_0006);
    gap;
    port(4'h0, 4'h0);
    wr(STEP_ADDR, 32'h0000_0001);
    gap;
    port(4'h0, 4'h0);
    rd(DATA_ADDR, r);
    chk(r, 32'h0000_0001);
    wr(CTRL_ADDR, 32'h0000_0007);
    wr(STEP_ADDR, 32'h0000_0001);
    gap;
    port(4'hA, 4'h5);
    // Feedback counter: last stage drives the first-stage controls.
    p = 4'h5;
    for (int k = 0; k < 4; k++)
    begin
      q = p[3];
      wr(CTRL_ADDR, {24'h0, 2'b00, q, !q, 4'h9});
      wr(STEP_ADDR, 32'h0000_0001);
      gap;
      p = {p[2:0], (!q & !p[0]) | (q & p[0])};
      port(4'hA, p);
    end
    close_out;
  end
endmodule
